//--- pimlc_pkg.sv
// Package for the per-port interrupt mask and operation control bank
package pimlc_pkg;
	localparam int          PIMLC_NUM_PORTS     = 7;
	localparam int          PIMLC_SGMII_SLOT    = 6;
	localparam logic [6:0]  PIMLC_PHY_PORTS     = 7'h1f;

	localparam logic [11:0] PIMLC_IDX_MASK      = 12'h01f;
	localparam logic [11:0] PIMLC_IDX_CTRL      = 12'h020;
	localparam logic [15:0] PIMLC_IDX_EVT_STAT  = 16'h0010;
	localparam logic [15:0] PIMLC_IDX_EVT_EN    = 16'h0011;

	localparam int          PIMLC_MSK_SGMII     = 3;
	localparam int          PIMLC_MSK_PTP       = 2;
	localparam int          PIMLC_MSK_PHY       = 1;
	localparam int          PIMLC_MSK_ACL       = 0;
	localparam int          PIMLC_CTL_LOCAL     = 7;
	localparam int          PIMLC_CTL_REMOTE    = 6;
	localparam int          PIMLC_CTL_TAIL      = 2;
	localparam int          PIMLC_CTL_QS_LO     = 0;
	localparam int          PIMLC_EVT_TAILMULTI = 7;

	localparam logic [3:0]  PIMLC_MASK_RST      = 4'h0;
	localparam logic [1:0]  PIMLC_QS_RST        = 2'h0;
	localparam logic [1:0]  PIMLC_QS_RSVD       = 2'h3;
	localparam logic [7:0]  PIMLC_EVT_RST       = 8'h00;

	localparam logic [1:0]  PIMLC_HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0]  PIMLC_HSIZE_WORD    = 3'h2;

	typedef enum logic [2:0] {
		PIMLC_ST_IDLE    = 3'b001,
		PIMLC_ST_RD_WAIT = 3'b010,
		PIMLC_ST_RD_DONE = 3'b100
	} pimlc_state_t;

	typedef struct packed {
		logic sgmii_an_done;
		logic ptp;
		logic phy;
		logic acl;
	} pimlc_cause_t;

	typedef struct packed {
		logic       local_loop;
		logic       remote_loop;
		logic       tail_tag;
		logic [1:0] queue_split;
	} pimlc_port_cfg_t;
endpackage

//--- pimlc_bank.sv
// Per-port interrupt mask and operation control register bank on AHB-Lite
// Operation
// - Ports 1 to 7 each have an 8-bit interrupt mask and 8-bit control register, port number in the top index nibble.
// - A port cause raises an interrupt only while its mask bit says enabled.
// - Mask bit 3 gates the SGMII auto-negotiation-done cause, 0 enables, and only port 7 uses it.
// - Mask bit 2 gates the aggregate PTP cause, 0 enables, on integrated PHY ports only.
// - Mask bit 1 gates the aggregate PHY cause, 0 enables, on integrated PHY ports only.
// - Mask bit 0 gates the ACL cause, 0 enables, on every port.
// - All mask bits reset to 0 and mask bits 7 to 4 read as zero.
// - Control bit 7 loops fabric egress traffic back into the fabric in the MAC, reset 0.
// - Control bit 6 loops traffic from the external pins back out the same port, reset 0.
// - Remote loopback runs RX pair to TX pair on PHY ports and TXD to RXD on media-independent ports.
// - Control bit 2 enables tail tagging and makes the port the host port, reset 0.
// - A pending ACL cause clears when software toggles mask bit 0.
// - Control bits 1:0 choose one, two or four egress queues, 11 reserved.
`timescale 1ns/10ps
`default_nettype none
module pimlc_bank
	import pimlc_pkg::*;
#(
	parameter logic [6:0] PHY_PORTS = PIMLC_PHY_PORTS
)(
	// Clock and reset
	input  wire logic                   CLOCK,
	input  wire logic                   RST_N,
	// AHB-Lite slave
	input  wire logic                   HSEL,
	input  wire logic [31:0]            HADDR,
	input  wire logic [1:0]             HTRANS,
	input  wire logic                   HWRITE,
	input  wire logic [2:0]             HSIZE,
	input  wire logic [31:0]            HWDATA,
	input  wire logic                   HREADY,
	output logic                        HREADYOUT,
	output logic                        HRESP,
	output logic [31:0]                 HRDATA,
	// Per-port causes, same clock domain
	input  wire pimlc_cause_t [6:0]     PORT_CAUSE,
	// Per-port interrupt requests and configuration
	output logic [6:0]                  PORT_IRQ_REQ,
	output pimlc_port_cfg_t [6:0]       PORT_CFG,
	output logic [6:0]                  PHY_REMOTE_LOOP,
	output logic [6:0]                  MII_REMOTE_LOOP,
	// Block interrupt
	output logic                        IRQ
);

	// Bus side
	pimlc_state_t           st_r;
	pimlc_state_t           st_nxt;
	logic [15:0]            idx_r;
	logic                   ok_r;
	logic                   wr_pend_r;
	logic [31:0]            rdata_r;
	logic                   a_take;
	logic                   a_ok;
	logic                   wr_ok;
	logic                   sel_stat;
	logic                   sel_en;
	logic [2:0]             rd_slot;
	logic [31:0]            rd_val;

	// Port side, each port owns its registers inside the generate loop
	logic [3:0]             mask_all [PIMLC_NUM_PORTS];
	pimlc_port_cfg_t [6:0]  cfg_all;
	logic [6:0]             preq_r;
	logic [6:0]             preq_nxt;
	logic [6:0]             tails;

	// Event side
	logic [7:0]             evt_stat_r;
	logic [7:0]             evt_en_r;
	logic                   multi_r;
	logic                   multi_nxt;
	logic [7:0]             evt_set;

	// Port slot for a register index, 3'h7 when no port matches
	function automatic logic [2:0] port_slot(input logic [15:0] idx);
		logic [3:0] n;
		n = idx[15:12];
		if (n >= 4'h1 && n <= 4'h7)
			return 3'(n - 4'h1);
		else
			return 3'h7;
	endfunction

	function automatic logic hit(input logic [15:0] idx, input int p, input logic [11:0] low);
		return (port_slot(idx) == 3'(p)) && (idx[11:0] == low);
	endfunction

	// True when idx names the given low register on a real port
	function automatic logic port_reg(input logic [15:0] idx, input logic [11:0] low);
		return (port_slot(idx) != 3'h7) && (idx[11:0] == low);
	endfunction

	// Control byte as software sees it; bits 5:3 are kept zero
	function automatic logic [7:0] ctrl_byte(input pimlc_port_cfg_t c);
		return {c.local_loop, c.remote_loop, 3'h0, c.tail_tag, c.queue_split};
	endfunction

	assign a_take = HSEL && HREADY && (HTRANS == PIMLC_HTRANS_NONSEQ || HTRANS == 2'h3);
	assign a_ok   = (HADDR[1:0] == 2'h0) && (HSIZE == PIMLC_HSIZE_WORD) && (HADDR[31:18] == 14'h0);

	// One decode of the captured index serves writes and reads alike
	assign wr_ok    = wr_pend_r && ok_r;
	assign sel_stat = (idx_r == PIMLC_IDX_EVT_STAT);
	assign sel_en   = (idx_r == PIMLC_IDX_EVT_EN);
	assign rd_slot  = port_slot(idx_r);

	// Address phase capture; reads take one wait state so a write just before is seen
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			idx_r     <= 16'h0000;
			ok_r      <= 1'b0;
			wr_pend_r <= 1'b0;
		end
		else
		begin
			wr_pend_r <= a_take && HWRITE;
			if (a_take)
			begin
				idx_r <= HADDR[17:2];
				ok_r  <= a_ok;
			end
		end
	end

	// Read sequencer; the wait state gives the read mux a whole cycle
	always_comb
	begin
		st_nxt = st_r;
		case (st_r)
			PIMLC_ST_IDLE, PIMLC_ST_RD_DONE:
				st_nxt = (a_take && !HWRITE) ? PIMLC_ST_RD_WAIT : PIMLC_ST_IDLE;
			PIMLC_ST_RD_WAIT:
				st_nxt = PIMLC_ST_RD_DONE;
			default:
				st_nxt = PIMLC_ST_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			st_r <= PIMLC_ST_IDLE;
		else
			st_r <= st_nxt;
	end

	// Only the read wait state stalls the bus; writes never do
	assign HREADYOUT = (st_r != PIMLC_ST_RD_WAIT);
	assign HRESP     = 1'b0;
	assign HRDATA    = rdata_r;

	// Per-port registers and interrupt gating
	genvar gp;
	generate
		for (gp = 0; gp < PIMLC_NUM_PORTS; gp++)
		begin : g_port
			localparam bit IS_PHY   = PHY_PORTS[gp];
			localparam bit IS_SGMII = (gp == PIMLC_SGMII_SLOT);
			logic                   wr_mask;
			logic                   wr_ctrl;
			logic [3:0]             cause_eff;
			logic [3:0]             mask_r;
			logic                   acl_pend_r;
			pimlc_port_cfg_t        cfg_r;

			assign wr_mask = wr_ok && hit(idx_r, gp, PIMLC_IDX_MASK);
			assign wr_ctrl = wr_ok && hit(idx_r, gp, PIMLC_IDX_CTRL);

			// Every port keeps all four mask bits, even where the cause is absent
			always_ff @(posedge CLOCK or negedge RST_N)
			begin
				if (!RST_N)
					mask_r <= PIMLC_MASK_RST;
				else if (wr_mask)
					mask_r <= HWDATA[3:0];
			end

			// An ACL event in the clearing cycle wins over the toggle
			always_ff @(posedge CLOCK or negedge RST_N)
			begin
				if (!RST_N)
					acl_pend_r <= 1'b0;
				else if (PORT_CAUSE[gp].acl)
					acl_pend_r <= 1'b1;
				else if (wr_mask && (HWDATA[PIMLC_MSK_ACL] != mask_r[PIMLC_MSK_ACL]))
					acl_pend_r <= 1'b0;
			end

			// Causes that do not apply to this port are held off
			assign cause_eff[PIMLC_MSK_SGMII] = IS_SGMII && PORT_CAUSE[gp].sgmii_an_done;
			assign cause_eff[PIMLC_MSK_PTP]   = IS_PHY && PORT_CAUSE[gp].ptp;
			assign cause_eff[PIMLC_MSK_PHY]   = IS_PHY && PORT_CAUSE[gp].phy;
			assign cause_eff[PIMLC_MSK_ACL]   = acl_pend_r;
			assign preq_nxt[gp] = |(cause_eff & ~mask_r);

			always_ff @(posedge CLOCK or negedge RST_N)
			begin
				if (!RST_N)
				begin
					cfg_r.local_loop  <= 1'b0;
					cfg_r.remote_loop <= 1'b0;
					cfg_r.tail_tag    <= 1'b0;
					cfg_r.queue_split <= PIMLC_QS_RST;
				end
				else if (wr_ctrl)
				begin
					cfg_r.local_loop  <= HWDATA[PIMLC_CTL_LOCAL];
					cfg_r.remote_loop <= HWDATA[PIMLC_CTL_REMOTE];
					cfg_r.tail_tag    <= HWDATA[PIMLC_CTL_TAIL];
					// The reserved split code would leave queues undefined, so keep the old one
					if (HWDATA[PIMLC_CTL_QS_LO +: 2] != PIMLC_QS_RSVD)
						cfg_r.queue_split <= HWDATA[PIMLC_CTL_QS_LO +: 2];
				end
			end

			assign PHY_REMOTE_LOOP[gp] = IS_PHY && cfg_r.remote_loop;
			assign MII_REMOTE_LOOP[gp] = !IS_PHY && cfg_r.remote_loop;
			assign tails[gp]           = cfg_r.tail_tag;
			// Gathered copies feed the read mux and the configuration port
			assign mask_all[gp]        = mask_r;
			assign cfg_all[gp]         = cfg_r;
		end
	endgenerate

	// Configuration leaves straight from the per-port registers
	assign PORT_CFG     = cfg_all;
	assign PORT_IRQ_REQ = preq_r;

	// More than one host port is a software slip; flag it rather than pick one
	assign multi_nxt = ($countones(tails) > 1);
	assign evt_set   = {multi_nxt && !multi_r, preq_nxt & ~preq_r};

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			preq_r  <= 7'h00;
			multi_r <= 1'b0;
		end
		else
		begin
			preq_r  <= preq_nxt;
			multi_r <= multi_nxt;
		end
	end

	// Sticky event status, write one to clear, a new event wins
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			evt_stat_r <= PIMLC_EVT_RST;
		else if (wr_ok && sel_stat)
			evt_stat_r <= (evt_stat_r & ~HWDATA[7:0]) | evt_set;
		else
			evt_stat_r <= evt_stat_r | evt_set;
	end

	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			evt_en_r <= PIMLC_EVT_RST;
		else if (wr_ok && sel_en)
			evt_en_r <= HWDATA[7:0];
	end

	// Level request; it drops only when software clears or disables the event
	assign IRQ = |(evt_stat_r & evt_en_r);

	// Read mux; reserved and unmapped bits read as zero
	always_comb
	begin
		rd_val = 32'h0000_0000;
		if (!ok_r)
			rd_val = 32'h0000_0000;
		else if (sel_stat)
			rd_val = {24'h000000, evt_stat_r};
		else if (sel_en)
			rd_val = {24'h000000, evt_en_r};
		else if (port_reg(idx_r, PIMLC_IDX_MASK))
			rd_val = {28'h0000000, mask_all[rd_slot]};
		else if (port_reg(idx_r, PIMLC_IDX_CTRL))
			rd_val = {24'h000000, ctrl_byte(cfg_all[rd_slot])};
	end

	// Read data holds until the next read, so a late sample still sees it
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			rdata_r <= 32'h0000_0000;
		else if (st_r == PIMLC_ST_RD_WAIT)
			rdata_r <= rd_val;
	end

endmodule
`default_nettype wire

//--- pimlc_properties.sv
// Checker for the port interrupt mask and control register bank
`timescale 1ns/10ps
`default_nettype none
module pimlc_properties
	import pimlc_pkg::*;
#(
	parameter logic [6:0] PHY_PORTS = PIMLC_PHY_PORTS
)(
	// Clock and reset
	input wire logic                  CLOCK,
	input wire logic                  RST_N,
	// Bus
	input wire logic                  HSEL,
	input wire logic [1:0]            HTRANS,
	input wire logic                  HWRITE,
	input wire logic                  HREADY,
	input wire logic                  HREADYOUT,
	input wire logic                  HRESP,
	input wire logic [31:0]           HRDATA,
	// Port configuration
	input wire pimlc_port_cfg_t [6:0] PORT_CFG,
	input wire logic [6:0]            PHY_REMOTE_LOOP,
	input wire logic [6:0]            MII_REMOTE_LOOP
);
	wire  taken = HSEL && HREADY && HTRANS[1];
	logic wr_dp_r;
	// Marks the write data phase, the only cycle allowed to move the config
	always_ff @(posedge CLOCK or negedge RST_N)
		if (!RST_N)
			wr_dp_r <= 1'b0;
		else
			wr_dp_r <= taken && HWRITE;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	resp_okay_a: assert property (HRESP == 1'b0)
		else $error("Bus response not okay");
	read_wait_a: assert property (taken && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("Read wait state wrong");
	write_ready_a: assert property (taken && HWRITE |=> HREADYOUT)
		else $error("Write data phase stalled");
	read_upper_a: assert property (HREADYOUT && $past(!HREADYOUT) |-> HRDATA[31:8] == 24'h0)
		else $error("Upper read data not zero");
	queue_rsvd_a: assert property (PORT_CFG[0].queue_split != PIMLC_QS_RSVD)
		else $error("Reserved queue split stored");
	phy_loop_a: assert property (PHY_REMOTE_LOOP[0] == (PORT_CFG[0].remote_loop && PHY_PORTS[0]))
		else $error("PHY remote loop wrong");
	mii_loop_a: assert property (MII_REMOTE_LOOP[6] == (PORT_CFG[6].remote_loop && !PHY_PORTS[6]))
		else $error("MII remote loop wrong");
	cfg_hold_a: assert property (!wr_dp_r |=> $stable(PORT_CFG))
		else $error("Config moved without a write");
endmodule
bind pimlc_bank pimlc_properties #(.PHY_PORTS(PHY_PORTS)) u_props (.CLOCK(CLOCK), .RST_N(RST_N),
	.HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE), .HREADY(HREADY), .HREADYOUT(HREADYOUT),
	.HRESP(HRESP), .HRDATA(HRDATA), .PORT_CFG(PORT_CFG), .PHY_REMOTE_LOOP(PHY_REMOTE_LOOP),
	.MII_REMOTE_LOOP(MII_REMOTE_LOOP));
`default_nettype wire

//--- test_pimlc_bank.sv
// Testbench for the port interrupt mask and control register bank
`timescale 1ns/10ps
`default_nettype none
module test_pimlc_bank;
	import pimlc_pkg::*;
	logic clock, rst_n, hsel, hwrite, irq, hrdy, hresp;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, q, t;
	logic [6:0] req, phy_lp, mii_lp;
	pimlc_cause_t [6:0] pc;
	pimlc_port_cfg_t [6:0] dcfg;
	int bad_count, n_compared, cyc;
	pimlc_bank dut (.CLOCK(clock), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HREADYOUT(hrdy),
		.HRESP(hresp), .HRDATA(hrdata), .PORT_CAUSE(pc), .PORT_IRQ_REQ(req), .PORT_CFG(dcfg),
		.PHY_REMOTE_LOOP(phy_lp), .MII_REMOTE_LOOP(mii_lp), .IRQ(irq));
	always #2.5 clock = ~clock;
	task summarize();
		$display("compared %0d wrong %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Bounded run; a hung handshake ends here as a mismatch
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			bad_count++;
			summarize();
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value %s exp %h got %h", n, e, g);
		end
	endtask
	function logic [31:0] ra(input int p, input logic [11:0] r);
		ra = {14'h0, p[3:0], r, 2'h0};
	endfunction
	task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1; haddr <= a; htrans <= PIMLC_HTRANS_NONSEQ; hwrite <= w;
		hsize <= PIMLC_HSIZE_WORD;
		do @(posedge clock); while (hrdy !== 1'b1);
		htrans <= 2'h0; hsel <= 1'b0; hwdata <= d;
		do @(posedge clock); while (hrdy !== 1'b1);
		q = hrdata;
	endtask
	task rd(input string n, input logic [31:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk(n, e, q);
	endtask
	task cz(input int i, input logic [3:0] c, input logic e);
		pc[i] <= pimlc_cause_t'(c);
		repeat (3) @(posedge clock);
		chk("port req", {31'h0, e}, {31'h0, req[i]});
		pc[i] <= '0;
		repeat (3) @(posedge clock);
	endtask
	initial
	begin
		clock = 0; rst_n = 0; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 0;
		hwdata = 0; pc = '0; bad_count = 0; n_compared = 0; cyc = 0;
		repeat (12) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		for (int p = 1; p < 8; p++)
		begin
			rd("mask", ra(p, PIMLC_IDX_MASK), 32'h0);
			rd("ctrl", ra(p, PIMLC_IDX_CTRL), 32'h0);
		end
		cz(0, 4'h2, 1'b1);
		cz(0, 4'h4, 1'b1);
		cz(0, 4'h8, 1'b0);
		cz(6, 4'h8, 1'b1);
		cz(6, 4'h2, 1'b0);
		rd("event status", {14'h0, PIMLC_IDX_EVT_STAT, 2'h0}, 32'h41);
		bus({14'h0, PIMLC_IDX_EVT_EN, 2'h0}, 1'b1, 32'h01);
		@(posedge clock);
		chk("irq on", 32'h1, {31'h0, irq});
		bus({14'h0, PIMLC_IDX_EVT_EN, 2'h0}, 1'b1, 32'h0);
		@(posedge clock);
		chk("irq masked", 32'h0, {31'h0, irq});
		bus({14'h0, PIMLC_IDX_EVT_STAT, 2'h0}, 1'b1, 32'h41);
		rd("status cleared", {14'h0, PIMLC_IDX_EVT_STAT, 2'h0}, 32'h0);
		bus(ra(1, PIMLC_IDX_MASK), 1'b1, 32'hff);
		rd("mask", ra(1, PIMLC_IDX_MASK), 32'h0f);
		cz(0, 4'h2, 1'b0);
		cz(0, 4'h4, 1'b0);
		cz(2, 4'h1, 1'b1);
		chk("acl pending", 32'h1, {31'h0, req[2]});
		bus(ra(3, PIMLC_IDX_MASK), 1'b1, 32'h01);
		bus(ra(3, PIMLC_IDX_MASK), 1'b1, 32'h00);
		repeat (3) @(posedge clock);
		chk("acl cleared", 32'h0, {31'h0, req[2]});
		for (int p = 1; p < 8; p++)
		begin
			// Only port 1 ever becomes the host port; no frames enter the loops
			t = (p == 1) ? 32'h04 : 32'h00;
			for (int s = 0; s < 3; s++)
			begin
				bus(ra(p, PIMLC_IDX_CTRL), 1'b1, 32'hf8 | t | 32'(s));
				rd("ctrl", ra(p, PIMLC_IDX_CTRL), 32'hc0 | t | 32'(s));
				chk("cfg", 32'h18 | t | 32'(s), 32'(dcfg[p-1]));
			end
			bus(ra(p, PIMLC_IDX_CTRL), 1'b1, 32'hc3 | t);
			rd("ctrl keep", ra(p, PIMLC_IDX_CTRL), 32'hc2 | t);
		end
		chk("phy loop", 32'h1f, 32'(phy_lp));
		chk("mii loop", 32'h60, 32'(mii_lp));
		rd("event status", {14'h0, PIMLC_IDX_EVT_STAT, 2'h0}, 32'h04);
		rd("unmapped", 32'h100, 32'h0);
		summarize();
	end
endmodule
`default_nettype wire
